// *** design/fsf_pkg.sv ***
// package of the fieldbus slave freeze/hold process-image block
// assumes a single 50 MHz clock domain, no software register access
package fsf_pkg;

	// ****************************************************************
	// sizes and ranges
	// ****************************************************************
	localparam int          IN_W      = 8;
	localparam int          OUT_W     = 8;
	localparam int          GRP_W     = 8;
	localparam int          DIAG_W    = 8;
	localparam int          FIFO_DEP  = 16;
	localparam logic [6:0]  ADDR_MIN  = 7'h01;
	localparam logic [6:0]  ADDR_MAX  = 7'h7d;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic        FRZ_RST   = 1'b0;
	localparam logic        HOLD_RST  = 1'b0;

	// ****************************************************************
	// group control command codes
	// ****************************************************************
	typedef enum logic [2:0] {
		FSF_CMD_NONE     = 3'b000,
		FSF_CMD_FREEZE   = 3'b001,
		FSF_CMD_UNFREEZE = 3'b010,
		FSF_CMD_HOLD     = 3'b011,
		FSF_CMD_RELEASE  = 3'b100
	} fsf_cmd_t;

	// ****************************************************************
	// reply state machine
	// ****************************************************************
	typedef enum logic [1:0] {
		FSF_ST_IDLE  = 2'b00,
		FSF_ST_REPLY = 2'b01
	} fsf_state_t;

endpackage : fsf_pkg

// *** design/fsf_stream_if.sv ***
// valid/ready stream carrier between the top and its fifo
// assumes both ends on the same clock
interface fsf_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : fsf_stream_if

// *** design/fsf_fifo.sv ***
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
module fsf_fifo #(
	parameter int W   = 8,
	parameter int DEP = 16
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	fsf_stream_if.snk wr,
	fsf_stream_if.src rd
);
	localparam int AW = $clog2(DEP);

	logic [W-1:0] mem [DEP];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	// full only at DEP words; the count is one bit wider than the pointers
	assign wr.ready = cnt_reg < (AW+1)'(DEP);
	assign rd.valid = cnt_reg != '0;
	assign rd.data  = mem[rp_reg];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	// storage, no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end

	// pointers and count
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEP - 1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEP - 1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : fsf_fifo

// *** design/fsf_slave.sv ***
// process-image control of a fieldbus slave: freeze, hold, diagnostics
// assumes a frame decoder upstream delivers commands and output words
// synchronous to ref_clk, and a transmitter downstream takes replies
//
// Overview of operation
// - freeze command latches all inputs; cyclic replies carry the snapshot
// - repeated freeze while frozen re-latches the present inputs
// - unfreeze command returns replies to live input values
// - after hold, new output data is stored, pins stay unchanged
// - each new hold drives pins with latest stored data
// - release command resumes per-frame output updates
// - diagnostic interrupt on fault appearing and clearing, if enabled; event pulse always
// - diagnostic events also shown in pollable station bits
// - station address must be 1 to 125, never 0
// - works at any bus bit rate 9.6 kbps to 12 Mbps
// - reply only to a master request, never start on own
// - acyclic transfers supported besides cyclic exchange
module fsf_slave #(
	parameter int IN_W  = fsf_pkg::IN_W,
	parameter int OUT_W = fsf_pkg::OUT_W,
	parameter int GRP_W = fsf_pkg::GRP_W,
	parameter int DW    = fsf_pkg::DIAG_W,
	parameter int DEP   = fsf_pkg::FIFO_DEP
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [6:0]       station_addr,
	input  wire logic [GRP_W-1:0] group_assign,
	input  wire logic             cmd_valid,
	input  wire logic [2:0]       cmd_code,
	input  wire logic [GRP_W-1:0] cmd_groups,
	input  wire logic             out_valid,
	input  wire logic [OUT_W-1:0] out_data,
	output logic                  out_ready,
	input  wire logic             req_valid,
	input  wire logic [6:0]       req_addr,
	input  wire logic             req_acyclic,
	input  wire logic [IN_W-1:0]  acyc_data,
	output logic                  rsp_valid,
	output logic [IN_W-1:0]       rsp_data,
	output logic                  rsp_acyclic,
	input  wire logic             rsp_ready,
	input  wire logic [IN_W-1:0]  in_pins,
	output logic [OUT_W-1:0]      out_pins,
	input  wire logic [DW-1:0]    fault_in,
	input  wire logic             diag_int_en,
	output logic                  diag_int,
	output logic [DW-1:0]         diag_status,
	output logic                  diag_event,
	output logic                  frozen,
	output logic                  held,
	output logic                  addr_ok
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	fsf_stream_if #(.W(OUT_W)) fifo_in ();
	fsf_stream_if #(.W(OUT_W)) fifo_out ();

	fsf_pkg::fsf_state_t st_reg;
	fsf_pkg::fsf_cmd_t   cmd;
	logic                frz_reg;
	logic                hold_reg;
	logic [IN_W-1:0]     snap_reg;
	logic [OUT_W-1:0]    stored_reg;
	logic [OUT_W-1:0]    pins_reg;
	logic [DW-1:0]       fault_reg;
	logic [DW-1:0]       dstat_reg;
	logic                dint_reg;
	logic                devt_reg;
	logic [IN_W-1:0]     rdata_reg;
	logic                racyc_reg;
	logic                grp_hit;
	logic                fault_chg;
	logic                frz_take;
	logic                unfrz_take;
	logic                hold_take;
	logic                rel_take;
	logic                poll_take;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// legal station address window
	function automatic logic addr_legal(input logic [6:0] a);
		return (a >= fsf_pkg::ADDR_MIN) && (a <= fsf_pkg::ADDR_MAX);
	endfunction : addr_legal

	// group command of one kind that selects one of our groups
	function automatic logic cmd_take(
		input logic              v,
		input logic              h,
		input fsf_pkg::fsf_cmd_t got,
		input fsf_pkg::fsf_cmd_t want
	);
		return v && h && (got == want);
	endfunction : cmd_take

	assign grp_hit   = |(cmd_groups & group_assign);
	assign cmd       = fsf_pkg::fsf_cmd_t'(cmd_code);
	assign addr_ok   = addr_legal(station_addr);
	assign fault_chg = fault_in != fault_reg;

	// only group commands steer freeze and hold
	// one strobe per command; unknown codes decode to none, so a
	// corrupted command byte leaves freeze and hold state untouched
	assign frz_take   = cmd_take(cmd_valid, grp_hit, cmd,
		fsf_pkg::FSF_CMD_FREEZE);
	assign unfrz_take = cmd_take(cmd_valid, grp_hit, cmd,
		fsf_pkg::FSF_CMD_UNFREEZE);
	assign hold_take  = cmd_take(cmd_valid, grp_hit, cmd,
		fsf_pkg::FSF_CMD_HOLD);
	assign rel_take   = cmd_take(cmd_valid, grp_hit, cmd,
		fsf_pkg::FSF_CMD_RELEASE);

	// a poll is taken only when idle and addressed to us
	assign poll_take  = req_valid && addr_ok && (req_addr == station_addr)
		&& (st_reg == fsf_pkg::FSF_ST_IDLE);

	// ****************************************************************
	// output data path through the fifo
	// ****************************************************************
	// upstream back-pressure reaches the frame decoder
	assign fifo_in.valid = out_valid;
	assign fifo_in.data  = out_data;
	assign out_ready     = fifo_in.ready;
	// always drained; never stalls, not even while a hold command lands
	assign fifo_out.ready = 1'b1;

	fsf_fifo #(
		.W   (OUT_W),
		.DEP (DEP)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wr      (fifo_in),
		.rd      (fifo_out)
	);

	// ****************************************************************
	// freeze state and input snapshot
	// ****************************************************************
	// reset unfrozen
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frz_reg <= fsf_pkg::FRZ_RST;
		end else if (frz_take) begin
			frz_reg <= 1'b1;
		end else if (unfrz_take) begin
			frz_reg <= 1'b0;
		end
	end

	// input snapshot; a repeat freeze overwrites the old picture
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			snap_reg <= '0;
		end else if (frz_take) begin
			snap_reg <= in_pins;
		end
	end

	// ****************************************************************
	// hold state and output pins
	// ****************************************************************
	// reset unheld
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hold_reg <= fsf_pkg::HOLD_RST;
		end else if (hold_take) begin
			hold_reg <= 1'b1;
		end else if (rel_take) begin
			hold_reg <= 1'b0;
		end
	end

	// latest output word, kept even while held
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stored_reg <= '0;
		end else if (fifo_out.valid) begin
			stored_reg <= fifo_out.data;
		end
	end

	// physical outputs; a hold landing with a word in flight sees the
	// word already stored one cycle earlier, a known one-cycle skew
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pins_reg <= '0;
		end else if (hold_take) begin
			pins_reg <= stored_reg;
		end else if (!hold_reg && fifo_out.valid) begin
			pins_reg <= fifo_out.data;
		end
	end

	// ****************************************************************
	// diagnostics
	// ****************************************************************
	// previous fault levels for change detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= fault_in;
		end
	end

	// event pulse on fault set or clear, enabled or not
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			devt_reg <= 1'b0;
		end else begin
			devt_reg <= fault_chg;
		end
	end

	// interrupt pulse only while enabled; an event seen while
	// masked is not replayed later, the station bits keep it instead
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dint_reg <= 1'b0;
		end else begin
			dint_reg <= fault_chg && diag_int_en;
		end
	end

	// station bits, cleared by read reply; set wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dstat_reg <= '0;
		end else begin
			dstat_reg <= (fault_in ^ fault_reg) | fault_in
				| (rsp_valid && rsp_ready ? '0 : dstat_reg);
		end
	end

	// ****************************************************************
	// reply engine
	// ****************************************************************
	// rate-agnostic, frame layer upstream
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= fsf_pkg::FSF_ST_IDLE;
		end else begin
			unique case (st_reg)
				fsf_pkg::FSF_ST_IDLE: begin
					if (poll_take) begin
						st_reg <= fsf_pkg::FSF_ST_REPLY;
					end
				end
				fsf_pkg::FSF_ST_REPLY: begin
					// reply stands until the transmitter takes it
					if (rsp_ready) begin
						st_reg <= fsf_pkg::FSF_ST_IDLE;
					end
				end
				default: begin
					// unused codes fall back to idle, never a stray reply
					st_reg <= fsf_pkg::FSF_ST_IDLE;
				end
			endcase
		end
	end

	// reply contents captured at the poll, stable while the reply stands
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= '0;
			racyc_reg <= 1'b0;
		end else if (poll_take) begin
			racyc_reg <= req_acyclic;
			if (req_acyclic) begin
				rdata_reg <= acyc_data;
			end else begin
				rdata_reg <= frz_reg ? snap_reg : in_pins;
			end
		end
	end

	assign rsp_valid   = st_reg == fsf_pkg::FSF_ST_REPLY;
	assign rsp_data    = rdata_reg;
	assign rsp_acyclic = racyc_reg;
	assign out_pins    = pins_reg;
	assign diag_int    = dint_reg;
	assign diag_event  = devt_reg;
	assign diag_status = dstat_reg;
	assign frozen      = frz_reg;
	assign held        = hold_reg;

endmodule : fsf_slave

// *** tb/fsf_slave_properties.sv ***
// checker of freeze, hold, poll and diagnostic port behaviour
// assumes it is bound onto fsf_slave, single clock domain
module fsf_slave_properties #(
	parameter int IN_W  = 8,
	parameter int OUT_W = 8,
	parameter int GRP_W = 8,
	parameter int DW    = 8
) (
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic [6:0]       station_addr,
	input wire logic [GRP_W-1:0] group_assign,
	input wire logic             cmd_valid,
	input wire logic [2:0]       cmd_code,
	input wire logic [GRP_W-1:0] cmd_groups,
	input wire logic             req_valid,
	input wire logic             rsp_valid,
	input wire logic [IN_W-1:0]  rsp_data,
	input wire logic             rsp_ready,
	input wire logic [OUT_W-1:0] out_pins,
	input wire logic             diag_int_en,
	input wire logic             diag_int,
	input wire logic             diag_event,
	input wire logic [DW-1:0]    diag_status,
	input wire logic             frozen,
	input wire logic             held,
	input wire logic             addr_ok
);
	// ********
	// group command decode
	// ********
	// a command counts only when one of our groups is selected
	logic hit;
	assign hit = cmd_valid && |(cmd_groups & group_assign);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	frz_set_a: assert property (hit && cmd_code == 3'h1 |=> frozen)
		else $error("freeze not taken");
	unfrz_a: assert property (hit && cmd_code == 3'h2 |=> !frozen)
		else $error("unfreeze not taken");
	hold_set_a: assert property (hit && cmd_code == 3'h3 |=> held)
		else $error("hold not taken");
	out_release_a: assert property (hit && cmd_code == 3'h4 |=> !held)
		else $error("release not taken");
	group_miss_a: assert property (cmd_valid && !hit |=>
		$stable(frozen) && $stable(held)) else $error("foreign group acted");
	poll_only_a: assert property ($rose(rsp_valid) |-> $past(req_valid))
		else $error("reply without poll");
	rsp_stands_a: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data)) else $error("reply dropped");
	int_gate_a: assert property (diag_int |->
		diag_event && $past(diag_int_en)) else $error("interrupt not gated");
	diag_bits_a: assert property (diag_event |-> diag_status != '0)
		else $error("event not in status");
	addr_range_a: assert property (addr_ok ==
		(station_addr >= 7'h01 && station_addr <= 7'h7d))
		else $error("address range wrong");
	pins_held_a: assert property (held && $past(held) &&
		!$past(cmd_valid) |-> $stable(out_pins)) else $error("pins moved");
endmodule : fsf_slave_properties

bind fsf_slave fsf_slave_properties #(.IN_W(IN_W), .OUT_W(OUT_W),
	.GRP_W(GRP_W), .DW(DW)) u_chk (.ref_clk, .rst, .station_addr,
	.group_assign, .cmd_valid, .cmd_code, .cmd_groups, .req_valid,
	.rsp_valid, .rsp_data, .rsp_ready, .out_pins, .diag_int_en, .diag_int,
	.diag_event, .diag_status, .frozen, .held, .addr_ok);

// *** tb/fsf_master_model.sv ***
// fieldbus master model: group commands, polls and output words
// assumes the slave takes requests at rising ref_clk
module fsf_master_model (
	input  wire logic       ref_clk,
	output logic            cmd_valid,
	output logic [2:0]      cmd_code,
	output logic [7:0]      cmd_groups,
	output logic            out_valid,
	output logic [7:0]      out_data,
	input  wire logic       out_ready,
	output logic            req_valid,
	output logic [6:0]      req_addr,
	output logic            req_acyclic,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	input  wire logic       rsp_acyclic,
	output logic            rsp_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// request tasks
	// ********
	// released groups, addresses and data show the inverse so stale values never match
	initial begin
		{cmd_valid, cmd_code, cmd_groups, out_valid, out_data} = '0;
		{req_valid, req_addr, req_acyclic, rsp_ready} = '0;
	end
	task automatic group_cmd(input logic [2:0] code, input logic [7:0] grp);
		@(posedge ref_clk) #1;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_groups = grp;
		@(posedge ref_clk) #1;
		cmd_valid = 1'b0;
		cmd_groups = ~grp;
	endtask : group_cmd
	task automatic poll(input logic [6:0] addr, input logic acyc,
		input int slow, output logic got, output logic [7:0] d,
		output logic a);
		got = 1'b0;
		@(posedge ref_clk) #1;
		req_valid = 1'b1;
		req_addr = addr;
		req_acyclic = acyc;
		@(posedge ref_clk) #1;
		req_valid = 1'b0;
		req_addr = ~addr;
		for (int i = 0; i < 12 && !got; i++) begin
			if (rsp_valid && i >= slow) begin
				rsp_ready = 1'b1;
				d = rsp_data;
				a = rsp_acyclic;
				got = 1'b1;
			end
			@(posedge ref_clk) #1;
		end
		rsp_ready = 1'b0;
	endtask : poll
	task automatic send(input logic [7:0] w, output logic got);
		got = 1'b0;
		@(posedge ref_clk) #1;
		out_valid = 1'b1;
		out_data = w;
		for (int i = 0; i < 8 && !got; i++) begin
			got = out_ready;
			@(posedge ref_clk) #1;
		end
		out_valid = 1'b0;
		out_data = ~w;
	endtask : send
endmodule : fsf_master_model

// *** tb/testbench.sv ***
// self-checking bench of fsf_slave driven by the master model
// assumes design files and the master model compiled first
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk = 1'b0, rst = 1'b1, diag_int_en = 1'b0;
	logic [6:0]  station_addr = 7'h2a, req_addr;
	logic [7:0]  group_assign = 8'h24, in_pins = 8'h00;
	logic [7:0]  acyc_data = 8'h00, fault_in = 8'h00;
	logic [7:0]  cmd_groups, out_data, rsp_data, out_pins, diag_status;
	logic [2:0]  cmd_code;
	logic        cmd_valid, out_valid, out_ready, req_valid, req_acyclic;
	logic        rsp_valid, rsp_acyclic, rsp_ready, diag_int, diag_event;
	logic        frozen, held, addr_ok;
	logic [31:0] lf = 32'h0001279b;
	int          n_mismatch = 0, n_checks = 0;
	logic [6:0]  addr_probe [4] = '{7'h01, 7'h7d, 7'h7e, 7'h00};
	// ********
	// harness and helpers
	// ********
	always #10 ref_clk = ~ref_clk;
	fsf_slave dut (.ref_clk, .rst, .station_addr, .group_assign, .cmd_valid,
		.cmd_code, .cmd_groups, .out_valid, .out_data, .out_ready, .req_valid,
		.req_addr, .req_acyclic, .acyc_data, .rsp_valid, .rsp_data,
		.rsp_acyclic, .rsp_ready, .in_pins, .out_pins, .fault_in, .diag_int_en,
		.diag_int, .diag_status, .diag_event, .frozen, .held, .addr_ok);
	fsf_master_model m (.ref_clk, .cmd_valid, .cmd_code, .cmd_groups,
		.out_valid, .out_data, .out_ready, .req_valid, .req_addr, .req_acyclic,
		.rsp_valid, .rsp_data, .rsp_acyclic, .rsp_ready);
	function automatic logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction : rnd
	task automatic conclude();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic check(input string s, input logic [7:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : check
	// a missing reply is a hang: count it and stop
	task automatic rd(input logic acyc, input int slow, output logic [7:0] d);
		logic g, a;
		m.poll(station_addr, acyc, slow, g, d, a);
		check("reply kind", {7'h00, a}, {7'h00, acyc});
		if (g !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
	endtask : rd
	task automatic put(input logic [7:0] w);
		logic g;
		m.send(w, g);
		check("word taken", {7'h00, g}, 8'h01);
		if (g !== 1'b1) begin
			conclude();
		end
		repeat (3) @(posedge ref_clk) #1;
	endtask : put
	// collects diagnostic pulses over a short window
	task automatic pulses(output logic pi, pe);
		{pi, pe} = 2'b00;
		repeat (4) begin
			@(posedge ref_clk) #1;
			pi |= diag_int;
			pe |= diag_event;
		end
	endtask : pulses
	// ********
	// main sequence
	// ********
	initial begin
		logic [7:0] a, b, d, w;
		logic       g, pi, pe;
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		check("reset modes", {6'h00, frozen, held}, 8'h00);
		check("reset pins", out_pins, 8'h00);
		for (int k = 0; k < 6; k++) begin
			a = rnd();
			b = a ^ (rnd() | 8'h01);
			in_pins = a;
			m.group_cmd(3'h1, rnd() | 8'h04);
			in_pins = b;
			rd(1'b0, k, d);
			check("frozen reply", d, a);
			m.group_cmd(3'h1, 8'h20);
			in_pins = b ^ (rnd() | 8'h01);
			m.group_cmd(3'h1, rnd() & 8'hdb);
			rd(1'b0, 0, d);
			check("refrozen reply", d, b);
			m.group_cmd(3'h2, 8'h24);
			rd(1'b0, 1, d);
			check("live reply", d, in_pins);
			acyc_data = rnd();
			rd(1'b1, 0, d);
			check("acyclic reply", d, acyc_data);
		end
		m.poll(station_addr ^ 7'h01, 1'b0, 0, g, d, a[0]);
		check("foreign poll", {7'h00, g}, 8'h00);
		// last probe leaves address 0 so the next poll must be refused
		foreach (addr_probe[i]) begin
			station_addr = addr_probe[i];
			#1;
			check("addr ok", {7'h00, addr_ok},
				(i < 2) ? 8'h01 : 8'h00);
		end
		m.poll(7'h00, 1'b0, 0, g, d, a[0]);
		check("addr zero poll", {7'h00, g}, 8'h00);
		station_addr = 7'h2a;
		w = rnd() | 8'h01;
		put(w);
		check("live pins", out_pins, w);
		m.group_cmd(3'h3, 8'h04);
		// held word always differs from the one on the pins
		d = w ^ (rnd() | 8'h01);
		put(d);
		check("held pins", out_pins, w);
		m.group_cmd(3'h3, 8'h20);
		check("rehold pins", out_pins, d);
		m.group_cmd(3'h4, 8'h24);
		w = d ^ (rnd() | 8'h01);
		put(w);
		check("released pins", out_pins, w);
		diag_int_en = 1'b1;
		fault_in = 8'h01;
		pulses(pi, pe);
		check("fault raise", {6'h00, pi, diag_status[0]}, 8'h03);
		fault_in = 8'h00;
		pulses(pi, pe);
		check("fault clear", {7'h00, pi}, 8'h01);
		diag_int_en = 1'b0;
		fault_in = 8'h02;
		pulses(pi, pe);
		check("masked fault", {6'h00, pi, pe}, 8'h01);
		check("sticky bits", diag_status, 8'h03);
		// a reply handshake clears what is gone, keeps what stands
		rd(1'b1, 0, d);
		check("polled bits", diag_status, 8'h02);
		conclude();
	end
endmodule : testbench
